// ### hub_port_status_words.sv
// Register bank holding per-channel enables, link state and overcurrent flags.
// Assumes APB master on pclk; channel status inputs synchronous to pclk.
//
// Design decisions made here: the APB slave port and the register addresses.
`timescale 1ns/1ps
module hub_port_status_words #(
    parameter int CHANNELS = 8
) (
    input  wire logic                pclk,
    input  wire logic                presetn,
    input  wire logic                psel,
    input  wire logic                penable,
    input  wire logic                pwrite,
    input  wire logic [7:0]          paddr,
    input  wire logic [31:0]         pwdata,
    input  wire logic [3:0]          pstrb,
    output      logic [31:0]         prdata,
    output      logic                pready,
    output      logic                pslverr,
    input  wire logic [CHANNELS-1:0] attached,
    input  wire logic [CHANNELS-1:0] high_speed_active,
    input  wire logic [CHANNELS-1:0] super_speed_active,
    input  wire logic [CHANNELS-1:0] overcurrent,
    output      logic [CHANNELS-1:0] high_speed_data_en,
    output      logic [CHANNELS-1:0] bus_power_en,
    output      logic [CHANNELS-1:0] super_speed_data_en,
    output      logic                irq
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic [31:0]         enable_map;
        logic [CHANNELS-1:0] oc_flag;
        logic [7:0]          irq_status;
        logic [7:0]          irq_mask;
        logic [31:0]         prdata;
        logic                pready;
        logic                pslverr;
        logic [CHANNELS-1:0] hs_en;
        logic [CHANNELS-1:0] pwr_en;
        logic [CHANNELS-1:0] ss_en;
        logic                irq;
    } state_s;

    state_s st;
    state_s next_st;

    // Builds a bank word of 4 lanes for the state view; oc_bank builds the overcurrent view
    function automatic logic [31:0] state_bank(input logic [3:0] att,
                                               input logic [3:0] err,
                                               input logic [3:0] hs,
                                               input logic [3:0] ss);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            w[i*hub_port_regs_pkg::LANE_WIDTH + hub_port_regs_pkg::LANE_ATTACH]      = att[i];
            w[i*hub_port_regs_pkg::LANE_WIDTH + hub_port_regs_pkg::LANE_ERROR]       = err[i];
            w[i*hub_port_regs_pkg::LANE_WIDTH + hub_port_regs_pkg::LANE_HIGH_SPEED]  = hs[i];
            w[i*hub_port_regs_pkg::LANE_WIDTH + hub_port_regs_pkg::LANE_SUPER_SPEED] = ss[i];
        end
        return w;
    endfunction

    function automatic logic [31:0] oc_bank(input logic [3:0] err);
        logic [31:0] w;
        w = 32'h0000_0000;
        for (int i = 0; i < 4; i++) begin
            w[i*hub_port_regs_pkg::LANE_WIDTH + hub_port_regs_pkg::LANE_OVERCURRENT] = err[i];
        end
        return w;
    endfunction

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        logic        access;
        logic        wr;
        logic        rd;
        logic [31:0] wmask;
        logic [CHANNELS-1:0] clr;
        logic [CHANNELS-1:0] rise;
        logic [7:0]  rdat;
        access = psel && penable && !st.pready;
        wr     = access && pwrite;
        rd     = access && !pwrite;
        wmask  = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
        clr    = '0;
        rise   = overcurrent & ~st.oc_flag;
        rdat   = 8'h00;
        next_st         = st;
        next_st.pready  = access;
        next_st.pslverr = 1'b0;
        if (access) begin
            next_st.prdata = 32'h0000_0000;
        end
        if (access) begin
            if (paddr == hub_port_regs_pkg::OFF_PORT_ENABLE_MAP) begin
                if (wr) begin
                    // Reserved odd upper bits are never stored
                    next_st.enable_map = (st.enable_map & ~(wmask & hub_port_regs_pkg::ENABLE_MAP_WMASK))
                                       | (pwdata & wmask & hub_port_regs_pkg::ENABLE_MAP_WMASK);
                end else begin
                    next_st.prdata = st.enable_map;
                end
            end else if (paddr == hub_port_regs_pkg::OFF_PORT_STATE_LOW_BANK) begin
                if (rd) next_st.prdata = state_bank(attached[3:0], st.oc_flag[3:0],
                                                    high_speed_active[3:0], super_speed_active[3:0]);
                else next_st.pslverr = 1'b1;
            end else if (paddr == hub_port_regs_pkg::OFF_PORT_STATE_HIGH_BANK) begin
                if (rd) next_st.prdata = state_bank(attached[7:4], st.oc_flag[7:4],
                                                    high_speed_active[7:4], super_speed_active[7:4]);
                else next_st.pslverr = 1'b1;
            end else if (paddr == hub_port_regs_pkg::OFF_OVERCURRENT_LOW_BANK) begin
                if (rd) next_st.prdata = oc_bank(st.oc_flag[3:0]);
                else next_st.pslverr = 1'b1;
            end else if (paddr == hub_port_regs_pkg::OFF_OVERCURRENT_HIGH_BANK) begin
                if (rd) next_st.prdata = oc_bank(st.oc_flag[7:4]);
                else next_st.pslverr = 1'b1;
            end else if (paddr == hub_port_regs_pkg::OFF_CLEAR_CHANNEL_ERROR) begin
                // Write a one per channel bit to clear that channel's flag
                if (wr && pstrb[0]) clr = pwdata[CHANNELS-1:0];
            end else if (paddr == hub_port_regs_pkg::OFF_IRQ_STATUS) begin
                if (rd) begin
                    rdat = st.irq_status;
                    next_st.prdata = {24'h000000, rdat};
                end
            end else if (paddr == hub_port_regs_pkg::OFF_IRQ_MASK) begin
                if (wr && pstrb[0]) next_st.irq_mask = pwdata[7:0];
                else if (rd) next_st.prdata = {24'h000000, st.irq_mask};
            end else begin
                next_st.pslverr = 1'b1;
            end
        end
        // Sticky flag: a new overcurrent wins over a clear in the same cycle
        next_st.oc_flag = (st.oc_flag & ~clr) | overcurrent;
        // Read of status clears it, but events arriving now still set
        if (rd && paddr == hub_port_regs_pkg::OFF_IRQ_STATUS) begin
            next_st.irq_status = rise;
        end else begin
            next_st.irq_status = st.irq_status | rise;
        end
        for (int n = 0; n < CHANNELS; n++) begin
            next_st.hs_en[n]  = next_st.enable_map[2*n];
            next_st.pwr_en[n] = next_st.enable_map[2*n+1];
            next_st.ss_en[n]  = next_st.enable_map[hub_port_regs_pkg::SS_BASE + 2*n];
        end
        next_st.irq = |(next_st.irq_status & next_st.irq_mask);
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st            <= '0;
            st.enable_map <= hub_port_regs_pkg::ENABLE_MAP_RESET;
            st.irq_mask   <= hub_port_regs_pkg::IRQ_MASK_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign prdata              = st.prdata;
    assign pready              = st.pready;
    assign pslverr             = st.pslverr;
    assign high_speed_data_en  = st.hs_en;
    assign bus_power_en        = st.pwr_en;
    assign super_speed_data_en = st.ss_en;
    assign irq                 = st.irq;

endmodule // hub_port_status_words

// ### hub_port_regs_pkg.sv
// Constants for the hub port enable and status register bank.
// Assumes an APB slave with 32-bit data and one word per register.
// What this block does
// - Bits 2n/2n+1: high-speed data, power enable
// - Bit 16+2n SuperSpeed enable; odd upper reserved
// - One access reads or writes all channels
// - Two banks; channel lane at 8*(n mod 4)
// - Lane bits: attach, error, high-speed, SuperSpeed
// - State error bit mirrors recorded overcurrent
// - Overcurrent at lane bit 0 of each lane
// - Per-channel clear resets both error bits
// - Bank read returns four channels' recorded (sticky) errors
package hub_port_regs_pkg;

    // ------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFF_PORT_ENABLE_MAP      = 8'h00;
    localparam logic [7:0] OFF_PORT_STATE_LOW_BANK  = 8'h04;
    localparam logic [7:0] OFF_PORT_STATE_HIGH_BANK = 8'h08;
    localparam logic [7:0] OFF_OVERCURRENT_LOW_BANK = 8'h0c;
    localparam logic [7:0] OFF_OVERCURRENT_HIGH_BANK = 8'h10;
    localparam logic [7:0] OFF_CLEAR_CHANNEL_ERROR  = 8'h14;
    localparam logic [7:0] OFF_IRQ_STATUS           = 8'h18;
    localparam logic [7:0] OFF_IRQ_MASK             = 8'h1c;

    // ------------------------------------------------------------
    // Field positions and reset values
    // ------------------------------------------------------------
    localparam int          SS_BASE            = 16;
    localparam int          LANE_WIDTH         = 8;
    localparam int          LANE_ATTACH        = 0;
    localparam int          LANE_ERROR         = 3;
    localparam int          LANE_HIGH_SPEED    = 4;
    localparam int          LANE_SUPER_SPEED   = 5;
    localparam int          LANE_OVERCURRENT   = 0;
    localparam logic [31:0] ENABLE_MAP_RESET   = 32'h0000_0000;
    localparam logic [31:0] ENABLE_MAP_WMASK   = 32'h5555_ffff;
    localparam logic [7:0]  IRQ_MASK_RESET     = 8'h00;

endpackage

// ### hub_port_status_words_asserts.sv
// Concurrent checks on the ports of the hub port register bank.
// Assumes the single pclk domain and active-low asynchronous presetn.
`timescale 1ns/1ps
module hub_port_status_words_asserts #(parameter int CHANNELS = 8) (
    input wire logic                pclk, presetn, psel, penable, pwrite, pready, pslverr,
    input wire logic                irq,
    input wire logic [7:0]          paddr,
    input wire logic [3:0]          pstrb,
    input wire logic [31:0]         pwdata, prdata,
    input wire logic [CHANNELS-1:0] high_speed_data_en, bus_power_en, super_speed_data_en
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    wire rd_done = pready && !pwrite;
    wire wr_map = pready && pwrite && paddr == 8'h00 && pstrb == 4'hf;
    property p_ready_wait; psel && penable && !pready |=> pready; endproperty
    a_ready_wait: assert property (p_ready_wait) else $error("no answer");
    property p_ready_pulse; pready |=> !pready; endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("long ready");
    property p_map_write;
        wr_map |-> high_speed_data_en[0] == pwdata[0] && bus_power_en[7] == pwdata[15]
            && super_speed_data_en[7] == pwdata[30];
    endproperty
    a_map_write: assert property (p_map_write) else $error("enable outputs");
    property p_map_lo; rd_done && paddr == 8'h00 |-> prdata[15:0] == {bus_power_en[7],
        high_speed_data_en[7], prdata[13:1], high_speed_data_en[0]}; endproperty
    a_map_lo: assert property (p_map_lo) else $error("map low half");
    property p_map_hi; rd_done && paddr == 8'h00 |-> (prdata[31:16] & 16'haaaa) == 16'h0
        && prdata[30] == super_speed_data_en[7]; endproperty
    a_map_hi: assert property (p_map_hi) else $error("map high half");
    property p_state_res; rd_done && paddr inside {8'h04, 8'h08}
        |-> (prdata & 32'hc6c6c6c6) == 32'h0; endproperty
    a_state_res: assert property (p_state_res) else $error("state reserved");
    property p_oc_res; rd_done && paddr inside {8'h0c, 8'h10}
        |-> (prdata & 32'hfefefefe) == 32'h0; endproperty
    a_oc_res: assert property (p_oc_res) else $error("error reserved");
    property p_ro_write; pready && pwrite && paddr inside {[8'h04:8'h10]} |-> pslverr; endproperty
    a_ro_write: assert property (p_ro_write) else $error("read-only write");
    c_write: cover property (wr_map);
    c_err: cover property (pready && pslverr);
    c_irq: cover property ($rose(irq));
endmodule // hub_port_status_words_asserts

bind hub_port_status_words hub_port_status_words_asserts #(.CHANNELS(CHANNELS)) u_chk (.*);

// ### tb.sv
// Self-checking bench for the hub port register bank over APB.
// Assumes the design answers every access within a few cycles.
`timescale 1ns/1ps
module tb;
    logic pclk = 1'b0, presetn, psel, penable, pwrite, pready, pslverr, irq;
    logic [7:0] paddr, att, hsa, ssa, oc, hs, bp, ss;
    logic [31:0] pwdata, prdata;
    logic [3:0] pstrb = 4'hf;
    int n_errors = 0, num_checks = 0;
    always #2.5 pclk = ~pclk;
    hub_port_status_words dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .attached(att),
        .high_speed_active(hsa), .super_speed_active(ssa), .overcurrent(oc),
        .high_speed_data_en(hs), .bus_power_en(bp), .super_speed_data_en(ss), .irq(irq));
    task automatic end_of_test();
        if (n_errors == 0 && num_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Idle cycle first, so a release and the next setup never share an edge
    task automatic acc(input logic w, input logic [7:0] a, input logic [31:0] d,
                       input logic [31:0] x, input logic xe);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin n_errors++; end_of_test(); end
        if (!w) chk(prdata, x);
        chk({31'h0, pslverr}, {31'h0, xe});
        psel <= 1'b0; penable <= 1'b0;
    endtask
    initial begin
        presetn <= 1'b0; psel <= 1'b0; penable <= 1'b0; pwrite <= 1'b0;
        paddr <= 8'h00; pwdata <= 32'h0; att <= 8'h81; hsa <= 8'h02; ssa <= 8'h40; oc <= 8'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        acc(0, 8'h00, 0, 32'h0, 0);
        acc(1, 8'h00, 32'hffffffff, 0, 0);
        chk({8'h0, ss, bp, hs}, 32'h00ffffff);
        acc(0, 8'h00, 0, 32'h5555ffff, 0);
        acc(1, 8'h00, 32'h40008001, 0, 0);
        chk({8'h0, ss, bp, hs}, 32'h00808001);
        acc(0, 8'h00, 0, 32'h40008001, 0);
        pstrb <= 4'h1;
        acc(1, 8'h00, 32'hffffffff, 0, 0);
        pstrb <= 4'hf;
        chk({8'h0, ss, bp, hs}, 32'h00808f0f);
        acc(0, 8'h00, 0, 32'h400080ff, 0);
        acc(0, 8'h04, 0, 32'h00001001, 0);
        acc(0, 8'h08, 0, 32'h01200000, 0);
        acc(1, 8'h1c, 32'h20, 0, 0);
        oc <= 8'h21;
        repeat (2) @(posedge pclk);
        oc <= 8'h00;
        repeat (3) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        acc(0, 8'h0c, 0, 32'h00000001, 0);
        acc(0, 8'h10, 0, 32'h00000100, 0);
        acc(0, 8'h08, 0, 32'h01200800, 0);
        acc(0, 8'h18, 0, 32'h00000021, 0);
        repeat (2) @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        acc(1, 8'h14, 32'h20, 0, 0);
        acc(0, 8'h10, 0, 32'h0, 0);
        acc(0, 8'h08, 0, 32'h01200000, 0);
        acc(0, 8'h04, 0, 32'h00001009, 0);
        acc(1, 8'h04, 32'hffffffff, 0, 1);
        acc(0, 8'h40, 0, 32'h0, 1);
        end_of_test();
    end
endmodule // tb
